// ===== hw/cma_cfg.svh
// Constants for the control memory access block
`ifndef CMA_CFG_SVH
`define CMA_CFG_SVH
// APB register offsets
`define CMA_OFF_DATA    12'h000
`define CMA_OFF_ADDR    12'h004
`define CMA_OFF_CTRL    12'h008
`define CMA_OFF_STAT    12'h00C
`define CMA_OFF_SUBSEL  12'h010
`define CMA_OFF_MODE    12'h014
// Field positions
`define CMA_CTL_RD_BIT  7
`define CMA_MOC_HI      6
`define CMA_MOC_LO      3
`define CMA_CMC_HI      3
`define CMA_CMC_LO      0
`define CMA_ADDR_UP_BIT 7
`define CMA_STAT_BUSY   0
`define CMA_MODE_OD_BIT 0
// Operation codes
`define CMA_MOC_CM_DATA 4'h9
`define CMA_MOC_CM_BOTH 3'h7
// Slot codes
`define CMA_CODE_OFF    4'h0
`define CMA_CODE_SW64   4'h1
`define CMA_CODE_SW32L  4'h2
`define CMA_CODE_SW32H  4'h3
`define CMA_CODE_SW16A  4'h4
`define CMA_CODE_SW16B  4'h5
`define CMA_CODE_SW16C  4'h6
`define CMA_CODE_SW16D  4'h7
`define CMA_CODE_PRE0   4'h8
`define CMA_CODE_PROC   4'h9
`define CMA_CODE_PRE1   4'hA
`define CMA_CODE_PRE2   4'hB
// Reset values and timing
`define CMA_RST_BYTE    8'h00
`define CMA_RST_WORD    32'h0000_0000
`define CMA_ACCESS_CYC  3'h4
`define CMA_BIT_DIV     4'hA
`endif

// ===== hw/cma_ctrl_mem.sv
// Control memory with indirect APB access and downstream output driver control
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "cma_cfg.svh"
module cma_ctrl_mem #(
  parameter int APB_ADDR_W = 12,
  parameter int SLOT_W     = 8
) (
  // Clock and reset
  input  wire  logic                  clock,
  input  wire  logic                  rst_n,
  // APB slave
  input  wire  logic [APB_ADDR_W-1:0] paddr,
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  cma_pkg::cma_word_type pwdata,
  output       cma_pkg::cma_word_type prdata,
  output       logic                  pready,
  output       logic                  pslverr,
  // Switched bit from the PCM side, asynchronous pin
  input  wire  logic                  pcm_bit,
  // Downstream serial output pin
  output       logic                  downstream_serial_out,
  output       logic                  downstream_serial_oe,
  // Current downstream slot description for the switching path
  output       logic [7:0]            sw_pointer,
  output       logic [7:0]            sw_lane_mask,
  output       cma_pkg::cma_kind_type slot_kind
);
  import cma_pkg::*;

  localparam int DEPTH = 1 << SLOT_W;

  // ==========================================================
  // Registers and memories
  logic [7:0]        mem_access_data_reg;
  logic [SLOT_W-1:0] mem_access_address_reg;
  logic [7:0]        mem_access_control_reg;
  logic [1:0]        subchannel_select_reg;
  logic              output_driver_select;
  logic              access_busy_flag;
  logic [2:0]        access_cnt;
  cma_state_type     state;
  logic [3:0]        code_mem [DEPTH];
  logic [7:0]        data_mem [DEPTH];

  logic [3:0]        memory_operation_code;
  logic [3:0]        ctrl_mem_code_bits;
  logic              op_read;
  logic              op_both;
  logic              op_done;

  assign memory_operation_code = mem_access_control_reg[`CMA_MOC_HI:`CMA_MOC_LO];
  assign ctrl_mem_code_bits    = mem_access_control_reg[`CMA_CMC_HI:`CMA_CMC_LO];
  assign op_read               = mem_access_control_reg[`CMA_CTL_RD_BIT];
  assign op_both               = memory_operation_code[3:1] == `CMA_MOC_CM_BOTH;
  assign op_done               = (state == CMA_RUN) && (access_cnt == 3'h0);

  // ==========================================================
  // APB slave
  logic [11:0] off;
  logic        wr_fire;
  logic        start_cmd;
  logic        mapped;
  logic [7:0]  wr_ctrl;
  logic [3:0]  wr_moc;

  assign off     = paddr[11:0];
  assign wr_fire = psel && penable && pready && pwrite;
  assign wr_ctrl = pwdata[7:0];
  assign wr_moc  = wr_ctrl[`CMA_MOC_HI:`CMA_MOC_LO];
  assign mapped  = (off == `CMA_OFF_DATA) || (off == `CMA_OFF_ADDR) ||
                   (off == `CMA_OFF_CTRL) || (off == `CMA_OFF_STAT) ||
                   (off == `CMA_OFF_SUBSEL) || (off == `CMA_OFF_MODE);
  assign start_cmd = wr_fire && (off == `CMA_OFF_CTRL) && !access_busy_flag &&
                     ((wr_moc == `CMA_MOC_CM_DATA) ||
                      (wr_moc[3:1] == `CMA_MOC_CM_BOTH));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `CMA_RST_WORD;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        case (off)
          `CMA_OFF_DATA:   prdata <= {24'h00_0000, mem_access_data_reg};
          `CMA_OFF_ADDR:   prdata <= {24'h00_0000, mem_access_address_reg};
          `CMA_OFF_CTRL:   prdata <= {24'h00_0000, mem_access_control_reg};
          `CMA_OFF_STAT:   prdata <= {31'h0000_0000, access_busy_flag};
          `CMA_OFF_SUBSEL: prdata <= {30'h0000_0000, subchannel_select_reg};
          `CMA_OFF_MODE:   prdata <= {31'h0000_0000, output_driver_select};
          default:         prdata <= `CMA_RST_WORD;
        endcase
      end
    end
  end

  // Writes to the access triple are ignored while an operation runs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_access_address_reg <= `CMA_RST_BYTE;
      mem_access_control_reg <= `CMA_RST_BYTE;
    end else if (wr_fire && !access_busy_flag) begin
      if (off == `CMA_OFF_ADDR)
        mem_access_address_reg <= pwdata[SLOT_W-1:0];
      if (off == `CMA_OFF_CTRL)
        mem_access_control_reg <= wr_ctrl;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      subchannel_select_reg <= 2'h0;
      output_driver_select  <= 1'b0;
    end else if (wr_fire) begin
      if (off == `CMA_OFF_SUBSEL)
        subchannel_select_reg <= pwdata[1:0];
      if (off == `CMA_OFF_MODE)
        output_driver_select <= pwdata[`CMA_MODE_OD_BIT];
    end
  end

  // Data register: software writes, read results land here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_access_data_reg <= `CMA_RST_BYTE;
    end else if (op_done && op_read) begin
      if (op_both)
        mem_access_data_reg <= {4'h0, code_mem[mem_access_address_reg]};
      else
        mem_access_data_reg <= data_mem[mem_access_address_reg];
    end else if (wr_fire && !access_busy_flag && off == `CMA_OFF_DATA) begin
      mem_access_data_reg <= wr_ctrl;
    end
  end

  // ==========================================================
  // Access sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state            <= CMA_IDLE;
      access_busy_flag <= 1'b0;
      access_cnt       <= 3'h0;
    end else begin
      case (state)
        CMA_IDLE: begin
          if (start_cmd) begin
            state            <= CMA_RUN;
            access_busy_flag <= 1'b1;
            access_cnt       <= `CMA_ACCESS_CYC - 3'h1;
          end
        end
        CMA_RUN: begin
          if (access_cnt == 3'h0) begin
            state            <= CMA_IDLE;
            access_busy_flag <= 1'b0;
          end else begin
            access_cnt <= access_cnt - 3'h1;
          end
        end
        default: begin
          state            <= CMA_IDLE;
          access_busy_flag <= 1'b0;
        end
      endcase
    end
  end

  // Memory write port
  always_ff @(posedge clock) begin
    if (op_done && !op_read) begin
      data_mem[mem_access_address_reg] <= mem_access_data_reg;
      if (op_both)
        code_mem[mem_access_address_reg] <= ctrl_mem_code_bits;
    end
  end

  // ==========================================================
  // Downstream serial engine
  logic              pcm_meta;
  logic              pcm_sync;
  logic [3:0]        div_cnt;
  logic              bit_tick;
  logic [2:0]        bit_idx;
  logic [SLOT_W-2:0] slot_cnt;
  logic [SLOT_W-1:0] cur_addr;
  logic [3:0]        cur_code;
  logic [7:0]        cur_data;
  logic              next_active;
  logic              next_bit;
  logic [7:0]        next_mask;
  cma_kind_type      next_kind;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pcm_meta <= 1'b0;
      pcm_sync <= 1'b0;
    end else begin
      pcm_meta <= pcm_bit;
      pcm_sync <= pcm_meta;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_cnt  <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= div_cnt == `CMA_BIT_DIV - 4'h1;
      div_cnt  <= (div_cnt == `CMA_BIT_DIV - 4'h1) ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // Bits go out 7 first; downstream slots have the direction bit clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bit_idx  <= 3'h7;
      slot_cnt <= '0;
    end else if (bit_tick) begin
      bit_idx <= bit_idx - 3'h1;
      if (bit_idx == 3'h0)
        slot_cnt <= slot_cnt + (SLOT_W-1)'(1);
    end
  end

  assign cur_addr = {1'b0, slot_cnt};
  assign cur_code = code_mem[cur_addr];
  assign cur_data = data_mem[cur_addr];

  always_comb begin
    next_active = 1'b0;
    next_mask   = 8'h00;
    next_kind   = CMA_KIND_OFF;
    next_bit    = cur_data[bit_idx];
    case (cur_code)
      `CMA_CODE_OFF: begin
        next_active = 1'b0;
      end
      `CMA_CODE_SW64: begin
        next_mask   = 8'hFF;
        next_active = 1'b1;
      end
      `CMA_CODE_SW32H, `CMA_CODE_SW32L: begin
        next_mask   = cur_code[0] ? 8'hF0 : 8'h0F;
        next_active = bit_idx[2] == !subchannel_select_reg[0];
      end
      `CMA_CODE_SW16D, `CMA_CODE_SW16C, `CMA_CODE_SW16B, `CMA_CODE_SW16A: begin
        next_mask   = 8'h03 << {cur_code[1:0], 1'b0};
        next_active = bit_idx[2:1] == ~subchannel_select_reg;
      end
      `CMA_CODE_PRE0, `CMA_CODE_PRE1, `CMA_CODE_PRE2: begin
        next_kind   = CMA_KIND_PREPRO;
        next_active = 1'b1;
      end
      `CMA_CODE_PROC: begin
        next_kind   = CMA_KIND_PROC;
        next_active = 1'b1;
      end
      default: begin
        next_active = 1'b0;
      end
    endcase
    if (next_mask != 8'h00) begin
      next_kind = CMA_KIND_SWITCH;
      next_bit  = pcm_sync;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      downstream_serial_out <= 1'b0;
      downstream_serial_oe  <= 1'b0;
      sw_pointer            <= `CMA_RST_BYTE;
      sw_lane_mask          <= `CMA_RST_BYTE;
      slot_kind             <= CMA_KIND_OFF;
    end else if (bit_tick) begin
      if (output_driver_select) begin
        downstream_serial_out <= 1'b0;
        downstream_serial_oe  <= next_active && !next_bit;
      end else begin
        downstream_serial_out <= next_bit;
        downstream_serial_oe  <= next_active;
      end
      sw_pointer   <= (next_kind == CMA_KIND_SWITCH) ? cur_data : `CMA_RST_BYTE;
      sw_lane_mask <= next_mask;
      slot_kind    <= next_kind;
    end
  end

  // ==========================================================
  // Checks
  busy_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    start_cmd |=> access_busy_flag [*4] ##1 !access_busy_flag)
    else $error("busy flag length wrong");

  busy_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
    access_busy_flag |=> $stable(mem_access_address_reg) && $stable(mem_access_control_reg))
    else $error("access registers changed while busy");

  code_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    op_done && !op_read && op_both
      |=> code_mem[$past(mem_access_address_reg)] == $past(ctrl_mem_code_bits))
    else $error("code field not written");

  data_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    op_done && !op_read |=> data_mem[$past(mem_access_address_reg)] == $past(mem_access_data_reg))
    else $error("data field not written");

  code_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    op_done && !op_both |=> $stable(code_mem[mem_access_address_reg]))
    else $error("code field changed by data access");

  code_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    op_done && op_read && op_both
      |=> mem_access_data_reg == {4'h0, code_mem[mem_access_address_reg]}
          && $stable(code_mem[mem_access_address_reg]))
    else $error("code read back wrong");

  data_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    op_done && op_read && !op_both |=> mem_access_data_reg == data_mem[mem_access_address_reg])
    else $error("data read back wrong");

  unassigned_a: assert property (@(posedge clock) disable iff (!rst_n)
    bit_tick && cur_code == `CMA_CODE_OFF |=> !downstream_serial_oe)
    else $error("unassigned slot driven");

  open_drain_a: assert property (@(posedge clock) disable iff (!rst_n)
    bit_tick && output_driver_select |=> !downstream_serial_out)
    else $error("open drain drove high");

  full_lane_a: assert property (@(posedge clock) disable iff (!rst_n)
    bit_tick && cur_code == `CMA_CODE_SW64 |=> sw_lane_mask == 8'hFF && sw_pointer == $past(cur_data))
    else $error("64k lane mask wrong");

endmodule

// ===== hw/cma_pkg.sv
// Types shared by the control memory access block
package cma_pkg;
  typedef logic [31:0] cma_word_type;
  typedef enum logic [1:0] {
    CMA_KIND_OFF    = 2'b00,
    CMA_KIND_SWITCH = 2'b01,
    CMA_KIND_PREPRO = 2'b10,
    CMA_KIND_PROC   = 2'b11
  } cma_kind_type;
  typedef enum logic [0:0] {
    CMA_IDLE = 1'b0,
    CMA_RUN  = 1'b1
  } cma_state_type;
endpackage

// ===== verif/tb_control_memory_access.sv
// Self-checking testbench for the control memory access block
`timescale 1ns/10ps
`include "cma_cfg.svh"
module tb_control_memory_access;
  import cma_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic                  clock;
  logic                  rst_n;
  logic [11:0]           paddr;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  cma_word_type          pwdata;
  cma_word_type          prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  pcm_bit;
  logic                  downstream_serial_out;
  logic                  downstream_serial_oe;
  logic [7:0]            sw_pointer;
  logic [7:0]            sw_lane_mask;
  cma_kind_type          slot_kind;
  int                    failures;
  int                    checks_done;
  int                    cycles = 0;
  cma_word_type          rd;
  logic                  err;
  cma_ctrl_mem dut (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .paddr                 (paddr),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .pcm_bit               (pcm_bit),
    .downstream_serial_out (downstream_serial_out),
    .downstream_serial_oe  (downstream_serial_oe),
    .sw_pointer            (sw_pointer),
    .sw_lane_mask          (sw_lane_mask),
    .slot_kind             (slot_kind)
  );
  // ==========================================
  // Clock, timeout and shared tasks
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input cma_word_type d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h0000_0001, 32'h0000_0000);
  endtask
  // Start an operation and poll busy until clear
  task automatic mem_op(input logic [7:0] addr, input logic [7:0] ctrl);
    int n;
    apb(1'b1, `CMA_OFF_ADDR, {24'h0000_00, addr});
    apb(1'b1, `CMA_OFF_CTRL, {24'h0000_00, ctrl});
    apb(1'b0, `CMA_OFF_STAT, 32'h0000_0000);
    chk("busy after start", 32'h0000_0001, rd);
    n = 0;
    while (rd[0] !== 1'b0 && n < 20) begin
      apb(1'b0, `CMA_OFF_STAT, 32'h0000_0000);
      n++;
    end
    chk("busy cleared", 32'h0000_0000, rd);
    apb(1'b0, `CMA_OFF_DATA, 32'h0000_0000);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [11:0] offs [6];
    offs = '{`CMA_OFF_DATA, `CMA_OFF_ADDR, `CMA_OFF_CTRL, `CMA_OFF_STAT, `CMA_OFF_SUBSEL,
             `CMA_OFF_MODE};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("reset value", 32'h0000_0000, rd);
    end
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped data", 32'h0000_0000, rd);
  endtask
  task automatic t_both();
    apb(1'b1, `CMA_OFF_DATA, 32'h0000_005A);
    mem_op(8'h7B, 8'h70);
    apb(1'b1, `CMA_OFF_DATA, 32'h0000_00C6);
    mem_op(8'hFB, 8'h71);
    mem_op(8'hFB, 8'hF5);
    chk("code read", 32'h0000_0001, rd);
    mem_op(8'hFB, 8'hC8);
    chk("data read", 32'h0000_00C6, rd);
    mem_op(8'h7B, 8'hC8);
    chk("other direction", 32'h0000_005A, rd);
  endtask
  task automatic t_data_only();
    apb(1'b1, `CMA_OFF_DATA, 32'h0000_003C);
    mem_op(8'hFB, 8'h48);
    mem_op(8'hFB, 8'hF0);
    chk("code kept", 32'h0000_0001, rd);
    mem_op(8'hFB, 8'hC8);
    chk("data only", 32'h0000_003C, rd);
  endtask
  task automatic t_codes();
    for (int c = 0; c < 12; c++) begin
      apb(1'b1, `CMA_OFF_DATA, 32'h0000_0010 + c);
      mem_op(c[7:0], 8'h70 | c[7:0]);
      mem_op(c[7:0], 8'hFA);
      chk("code loop", c, rd);
    end
  endtask
  task automatic t_lanes();
    logic [7:0] masks [8];
    int         bits [8];
    int         n;
    int         on;
    int         ones;
    masks = '{8'h00, 8'hFF, 8'h0F, 8'hF0, 8'h03, 8'h0C, 8'h30, 8'hC0};
    bits  = '{0, 8, 4, 4, 2, 2, 2, 2};
    pcm_bit <= 1'b1;
    repeat (100) @(posedge clock);
    // Park before slot 1 so its whole duration is counted
    n = 0;
    while (!(sw_pointer === 8'h00 && slot_kind === CMA_KIND_OFF) && n < 12000) begin
      @(posedge clock);
      n++;
    end
    for (int c = 1; c < 8; c++) begin
      while (sw_pointer !== (8'h10 + c[7:0]) && n < 24000) begin
        @(posedge clock);
        n++;
      end
      chk("pointer", 32'h0000_0010 + c, {24'h0000_00, sw_pointer});
      chk("lane mask", masks[c], {24'h0000_00, sw_lane_mask});
      chk("kind", {30'h0000_0000, CMA_KIND_SWITCH}, {30'h0000_0000, slot_kind});
      on = 0;
      ones = 0;
      while (sw_pointer === (8'h10 + c[7:0]) && n < 24000) begin
        if (downstream_serial_oe === 1'b1) on++;
        if (downstream_serial_out === 1'b1) ones++;
        @(posedge clock);
        n++;
      end
      chk("active cycles", bits[c] * `CMA_BIT_DIV, on);
      chk("switched bits", 8 * `CMA_BIT_DIV, ones);
    end
    chk("kind prepro", {30'h0000_0000, CMA_KIND_PREPRO}, {30'h0000_0000, slot_kind});
    repeat (8 * `CMA_BIT_DIV) @(posedge clock);
    chk("kind proc", {30'h0000_0000, CMA_KIND_PROC}, {30'h0000_0000, slot_kind});
  endtask
  task automatic t_odrain();
    int bad;
    int idle;
    int on;
    bad = 0;
    idle = 0;
    on = 0;
    pcm_bit <= 1'b0;
    apb(1'b1, `CMA_OFF_MODE, 32'h0000_0001);
    // Outputs follow the mode only from the next bit tick
    repeat (2 * `CMA_BIT_DIV) @(posedge clock);
    repeat (10400) begin
      @(posedge clock);
      if (downstream_serial_out !== 1'b0) bad++;
      if (slot_kind === CMA_KIND_OFF && downstream_serial_oe !== 1'b0) idle++;
      if (downstream_serial_oe === 1'b1) on++;
    end
    chk("open drain high", 32'h0000_0000, bad);
    chk("unassigned driven", 32'h0000_0000, idle);
    chk("open drain driven", 32'h0000_0001, {31'h0000_0000, on > 0});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst_n       = 1'b0;
    paddr       = 12'h000;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    pwdata      = 32'h0000_0000;
    pcm_bit     = 1'b0;
    failures    = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_both();
    t_data_only();
    t_codes();
    t_lanes();
    t_odrain();
    summarize();
  end
endmodule
